// ===== src/pot_defines.vh
// Constants for the prescaled overflow timer: APB offsets, fields, timing.
// Assumes inclusion by bare name from files under src/.
`ifndef POT_DEFINES_VH
`define POT_DEFINES_VH

`define POT_OFF_COUNT_LOW 12'h000
`define POT_OFF_COUNT_HIGH 12'h004
`define POT_OFF_CONTROL 12'h008
`define POT_OFF_FLAGS 12'h00C
`define POT_OFF_INT_ENABLE 12'h010
`define POT_OFF_STATUS 12'h014

`define POT_CTL_SRC0 0
`define POT_CTL_SRC1 1
`define POT_CTL_PRE0 2
`define POT_CTL_PRE1 3
`define POT_CTL_BYTE_FLAG 4
`define POT_CTL_CLR_EN 5
`define POT_CTL_BYTE_SEL 6
`define POT_CTL_FULL_SEL 7
`define POT_FLAGS_FULL 7
`define POT_IEN_ENABLE 7

`define POT_CONTROL_RESET 8'h00
`define POT_OSC_DIV 12
`define POT_STATES 6
`define POT_PHASES 2
`define POT_SAMPLE_A 4'h2
`define POT_SAMPLE_B 4'h8
`define POT_STATE_S6 4'hA

`endif

// ===== src/pot_edge_detect.v
// Two-sample rising-edge detector used for the count and clear inputs.
// Assumes the input is synchronous to pclk; sample strobes come from caller.
`timescale 1ns/1ps
`default_nettype none
module pot_edge_detect (
    input wire pclk,
    input wire presetn,
    input wire sample,
    input wire din,
    output reg rise
);
    reg last_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg <= 1'b0;
            rise <= 1'b0;
        end else begin
            rise <= 1'b0;
            if (sample) begin
                last_reg <= din;
                rise <= din & ~last_reg;
            end
        end
    end
endmodule // pot_edge_detect
`default_nettype wire

// ===== src/pot_phase_gen.v
// Machine cycle state generator: one pclk per phase, twelve phases a cycle.
// Assumes pclk stands for the oscillator clock.
`timescale 1ns/1ps
`default_nettype none
module pot_phase_gen (
    input wire pclk,
    input wire presetn,
    output reg [3:0] phase,
    output reg cycle_end
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
            cycle_end <= 1'b0;
        end else begin
            if (phase == 4'hB) begin
                phase <= 4'h0;
            end else begin
                phase <= phase + 4'h1;
            end
            cycle_end <= (phase == 4'hA);
        end
    end
endmodule // pot_phase_gen
`default_nettype wire

// ===== src/pot_timer.v
// Prescaled 16-bit overflow timer with an APB register slave.
// Assumes synchronous pins, pclk as oscillator, machine cycle of 12 clocks.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pot_defines.vh"
// Behaviour
// - 16-bit count readable as two bytes
// - Stopped, or osc/12, or external source
// - External rising edges advance the prescaler
// - Sample input at S2P1, S5P1; detect low-high
// - Early edge counts next cycle, else later
// - Prescale 1/2/4/8, cleared on change or clear
// - Count readable live, never writable
// - Enabled clear edge zeroes timer, prescaler
// - Byte, full overflow flags set next cycle
// - Full overflow also sets byte flag
// - Byte interrupt needs enable and select
// - Full interrupt needs enable and select
// - Both requests share one interrupt output
// - Only software clears the overflow flags
// - Byte flag at control bit 4
// - Idle holds timer and prescaler cleared
// - Source 01 is osc/12; prescale 11 is /8
// - Flags set in S6, seen next cycle
module pot_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire external_count_input,
    input wire external_clear_input,
    input wire idle_mode,
    output reg timer_irq
);
    wire [3:0] phase;
    wire cycle_end;
    wire count_rise;
    wire clear_rise;
    wire s2p1;
    wire s5p1;
    wire s6;

    reg [7:0] control_reg;
    reg full_flag_reg;
    reg int_enable_reg;
    reg [7:0] count_low_byte_reg;
    reg [7:0] count_high_byte_reg;
    reg [2:0] prescale_reg;
    reg [3:0] cfg_last_reg;
    reg ext_pend_reg;
    reg ext_late_reg;
    reg ext_due_reg;
    reg tick_due_reg;
    reg low_ovf_reg;
    reg full_ovf_reg;
    reg low_ovf_seen_reg;
    reg full_ovf_seen_reg;

    wire [1:0] src_sel;
    wire [1:0] pre_sel;
    wire [2:0] pre_mask;
    wire cfg_change;
    wire clear_now;
    wire src_tick;
    wire pre_out;
    wire [15:0] count_now;
    wire [16:0] count_inc;
    wire apb_write;
    wire apb_read;
    wire set_byte_flag;
    wire set_full_flag;
    reg [31:0] rdata_next;
    reg decode_err;

    assign s2p1 = (phase == `POT_SAMPLE_A);
    assign s5p1 = (phase == `POT_SAMPLE_B);
    assign s6 = (phase == `POT_STATE_S6);
    assign src_sel = {control_reg[`POT_CTL_SRC1], control_reg[`POT_CTL_SRC0]};
    assign pre_sel = {control_reg[`POT_CTL_PRE1], control_reg[`POT_CTL_PRE0]};

    pot_phase_gen u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    pot_edge_detect u_count_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sample(s2p1 | s5p1),
        .din(external_count_input),
        .rise(count_rise)
    );

    pot_edge_detect u_clear_edge (
        .pclk(pclk),
        .presetn(presetn),
        .sample(s2p1 | s5p1),
        .din(external_clear_input),
        .rise(clear_rise)
    );

    // Binary prescale code, mask of low prescaler bits that must be ones
    assign pre_mask = (pre_sel == 2'b00) ? 3'b000 :
                      (pre_sel == 2'b01) ? 3'b001 :
                      (pre_sel == 2'b10) ? 3'b011 : 3'b111;
    assign cfg_change = ({src_sel, pre_sel} != cfg_last_reg);
    assign clear_now = idle_mode |
                       (control_reg[`POT_CTL_CLR_EN] & clear_rise) |
                       cfg_change;
    // One source tick per machine cycle at most, on the cycle boundary
    assign src_tick = cycle_end & ((src_sel == 2'b01) |
                      (src_sel[1] & ext_due_reg));
    assign pre_out = src_tick & ((prescale_reg & pre_mask) == pre_mask);
    assign count_now = {count_high_byte_reg, count_low_byte_reg};
    assign count_inc = {1'b0, count_now} + 17'h00001;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= 3'h0;
            cfg_last_reg <= 4'h0;
            ext_pend_reg <= 1'b0;
            ext_late_reg <= 1'b0;
            ext_due_reg <= 1'b0;
            count_low_byte_reg <= 8'h00;
            count_high_byte_reg <= 8'h00;
            low_ovf_reg <= 1'b0;
            full_ovf_reg <= 1'b0;
            tick_due_reg <= 1'b0;
        end else begin
            cfg_last_reg <= {src_sel, pre_sel};
            tick_due_reg <= pre_out;
            if (clear_now) begin
                prescale_reg <= 3'h0;
                ext_pend_reg <= 1'b0;
                ext_late_reg <= 1'b0;
                ext_due_reg <= 1'b0;
                count_low_byte_reg <= 8'h00;
                count_high_byte_reg <= 8'h00;
                low_ovf_reg <= 1'b0;
                full_ovf_reg <= 1'b0;
            end else begin
                // Edge seen by S2P1 counts next cycle, later edge one more
                if (count_rise && phase <= `POT_SAMPLE_A + 4'h1) begin
                    ext_pend_reg <= 1'b1;
                end else if (count_rise) begin
                    ext_late_reg <= 1'b1;
                end
                // Late edge waits one extra machine cycle in the pipe
                if (cycle_end) begin
                    ext_due_reg <= ext_pend_reg;
                    ext_pend_reg <= ext_late_reg;
                    ext_late_reg <= 1'b0;
                    low_ovf_reg <= 1'b0;
                    full_ovf_reg <= 1'b0;
                end
                if (src_tick) begin
                    prescale_reg <= prescale_reg + 3'h1;
                end
                if (pre_out) begin
                    count_low_byte_reg <= count_inc[7:0];
                    count_high_byte_reg <= count_inc[15:8];
                    low_ovf_reg <= (count_low_byte_reg == 8'hFF);
                    full_ovf_reg <= count_inc[16];
                end
            end
        end
    end

    // Overflows happen at cycle start; flags rise at S6 of that cycle
    assign set_byte_flag = s6 & (low_ovf_reg | full_ovf_reg);
    assign set_full_flag = s6 & full_ovf_reg;

    assign apb_write = psel & penable & pwrite;
    assign apb_read = psel & ~pwrite;

    always @* begin
        rdata_next = 32'h00000000;
        decode_err = 1'b0;
        case (paddr)
            `POT_OFF_COUNT_LOW: rdata_next[7:0] = count_low_byte_reg;
            `POT_OFF_COUNT_HIGH: rdata_next[7:0] = count_high_byte_reg;
            `POT_OFF_CONTROL: rdata_next[7:0] = control_reg;
            `POT_OFF_FLAGS: rdata_next[`POT_FLAGS_FULL] = full_flag_reg;
            `POT_OFF_INT_ENABLE: rdata_next[`POT_IEN_ENABLE] = int_enable_reg;
            `POT_OFF_STATUS: rdata_next[3:0] = phase;
            default: decode_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= `POT_CONTROL_RESET;
            full_flag_reg <= 1'b0;
            int_enable_reg <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            timer_irq <= 1'b0;
            low_ovf_seen_reg <= 1'b0;
            full_ovf_seen_reg <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & decode_err;
            if (psel && !penable && apb_read) begin
                prdata <= rdata_next;
            end
            low_ovf_seen_reg <= set_byte_flag;
            full_ovf_seen_reg <= set_full_flag;
            if (apb_write && pready && !pslverr) begin
                case (paddr)
                    `POT_OFF_CONTROL: control_reg <= pwdata[7:0];
                    `POT_OFF_FLAGS:
                        full_flag_reg <= pwdata[`POT_FLAGS_FULL];
                    `POT_OFF_INT_ENABLE:
                        int_enable_reg <= pwdata[`POT_IEN_ENABLE];
                    default: control_reg <= control_reg;
                endcase
            end
            // Set beats a software clear in the same cycle
            if (set_byte_flag) begin
                control_reg[`POT_CTL_BYTE_FLAG] <= 1'b1;
            end
            if (set_full_flag) begin
                full_flag_reg <= 1'b1;
            end
            // Shared request, recognised from the cycle after the flag
            timer_irq <= int_enable_reg &
                ((control_reg[`POT_CTL_BYTE_SEL] &
                  control_reg[`POT_CTL_BYTE_FLAG]) |
                 (control_reg[`POT_CTL_FULL_SEL] & full_flag_reg));
        end
    end
endmodule // pot_timer
`default_nettype wire

// ===== tb/pot_timer_chk.sv
// Port-level assertions for the prescaled overflow timer.
// Assumes it is bound onto pot_timer.
`timescale 1ns/1ps
`default_nettype none
module pot_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic idle_mode,
    input wire logic timer_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_done = psel && penable && pready && !pwrite;
    wire logic wr_acc = psel && penable && pwrite;
    ready_next_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_when_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    unmapped_err_a: assert property (pready && paddr > 12'h014 |-> pslverr)
        else $error("unmapped not refused");
    byte_width_a: assert property (rd_done && paddr < 12'h008 |->
        prdata[31:8] == 24'h0)
        else $error("count wider than a byte");
    idle_zero_a: assert property (idle_mode [*4] ##0
        (rd_done && paddr < 12'h008) |-> prdata == 32'h0)
        else $error("count moves in idle");
    irq_fall_a: assert property ($fell(timer_irq) |-> $past(wr_acc, 2) || $past(wr_acc))
        else $error("irq dropped without write");
    cover property (pslverr);
    cover property ($rose(timer_irq));
    cover property (idle_mode ##0 rd_done);
endmodule // pot_timer_chk
bind pot_timer pot_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .timer_irq(timer_irq));
`default_nettype wire

// ===== tb/pot_pulse_src.sv
// Pulse source on the external count pin, six pulses per go.
// Assumes go lasts one clock while busy is low.
`timescale 1ns/1ps
`default_nettype none
module pot_pulse_src (
    input wire logic pclk,
    input wire logic go,
    input wire logic [3:0] half,
    output logic pin,
    output logic busy
);
    logic [3:0] cnt_reg = 4'h0;
    logic [2:0] left_reg = 3'h0;
    // Starts low, matching the detector's reset sample, so no false edge
    initial pin = 1'b0;
    initial busy = 1'b0;
    always @(posedge pclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            left_reg <= 3'h6;
            pin <= 1'b0;
        end else if (busy) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == half - 4'h1) begin
                cnt_reg <= 4'h0;
                pin <= ~pin;
                left_reg <= left_reg - {2'h0, !pin};
                busy <= !(left_reg == 3'h1 && !pin);
            end
        end
    end
endmodule // pot_pulse_src
`default_nettype wire

// ===== tb/pot_timer_tb.sv
// Bench for the prescaled overflow timer.
// Assumes the pulse source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pot_timer_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, clr = 1'b0, idle = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] half = 4'h6;
    logic [31:0] prdata, rd, a;
    logic pready, pslverr, irq, pin, busy, e;
    int mismatches = 0, checked = 0, cycles = 0, n;
    always #4 pclk = ~pclk;
    pot_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(pin), .external_clear_input(clr),
        .idle_mode(idle), .timer_irq(irq));
    pot_pulse_src u_src (.pclk(pclk), .go(go), .half(half), .pin(pin),
        .busy(busy));
    task automatic cmp(input string w, input logic [31:0] x, y);
        checked++;
        if (y !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", w, x, y);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad,
        input logic [31:0] wd = 32'h0);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b1, 12'h000, 32'h5A);
        apb(1'b0, 12'h000);
        cmp("count low", 32'h0, rd);
        apb(1'b0, 12'h040);
        cmp("slverr", 32'h1, {31'h0, e});
    endtask
    task automatic t_rate();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h008, c * 4 + 1);
            cyc(4);
            apb(1'b0, 12'h000);
            a = rd;
            cyc(381);
            apb(1'b0, 12'h000);
            cmp("osc rate", a + (32 >> c), rd);
        end
    endtask
    task automatic t_ext();
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, 12'h008, c * 4 + 2);
            cyc(4);
            apb(1'b0, 12'h000);
            a = rd;
            half <= c ? 4'h9 : 4'h6;
            go <= 1'b1;
            cyc(1);
            go <= 1'b0;
            cyc(1);
            while (busy !== 1'b0) @(posedge pclk);
            cyc(60);
            apb(1'b0, 12'h000);
            cmp("ext count", a + (6 >> c), rd);
        end
    endtask
    task automatic t_clr();
        apb(1'b1, 12'h008, 32'h21);
        cyc(300);
        clr <= 1'b1;
        cyc(20);
        apb(1'b0, 12'h000);
        cmp("cleared", 32'h1, {31'h0, rd <= 3});
        apb(1'b1, 12'h008, 32'h01);
        clr <= 1'b0;
        cyc(300);
        clr <= 1'b1;
        cyc(20);
        apb(1'b0, 12'h000);
        cmp("clear off", 32'h1, {31'h0, rd >= 20});
        idle <= 1'b1;
        cyc(30);
        apb(1'b0, 12'h000);
        cmp("idle count", 32'h0, rd);
    endtask
    task automatic t_byte();
        apb(1'b1, 12'h010, 32'h80);
        apb(1'b1, 12'h008, 32'h41);
        idle <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 3200) begin
            @(posedge pclk);
            n++;
        end
        cmp("irq time", 32'h1, {31'h0, n > 3040 && n < 3120});
        apb(1'b0, 12'h008);
        cmp("byte flag", 32'h51, rd);
        apb(1'b0, 12'h00C);
        cmp("full flag", 32'h0, rd);
        apb(1'b1, 12'h008, 32'h01);
        cyc(3);
        cmp("irq clear", 32'h0, {31'h0, irq});
        cyc(3200);
        apb(1'b0, 12'h008);
        cmp("flag kept", 32'h11, rd);
        cmp("irq masked", 32'h0, {31'h0, irq});
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cyc(5);
        presetn <= 1'b1;
        cyc(1);
        t_regs();
        t_rate();
        t_ext();
        t_clr();
        t_byte();
        results();
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
endmodule // pot_timer_tb
`default_nettype wire
